// *** hw/oscillator_warmup_counter.sv ***
// Function
// RULE1: software enables the slow oscillator before starting a slow warm-up.
// RULE2: writing the run bit to 1 starts the counter counting up.
// RULE3: on compare match the counter clears and the match interrupt is raised.
// RULE4: slow handler stops the timer, then sets clock select to 1.
// RULE5: after moving to slow clock, software clears the fast oscillator enable.
// RULE6: software enables the fast oscillator before starting a fast warm-up.
// RULE7: fast handler stops the timer, then clears clock select to 0.
// RULE8: after returning to fast clock, software clears the slow oscillator enable.
// RULE9: slow clock compare 0100h to ff00h spans 7.81 ms to 1.99 s.
// RULE10: fast clock compare 0100h to ff00h spans 16 us to 4.08 ms.
// RULE11: system control bit 7 fast enable, bit 6 slow enable, bit 5 select.
// RULE12: upper control 05h selects warm-up mode, flip-flop 0, not running.
// RULE13: lower control 43h selects slow clock, cascaded, flip-flop 0.
// RULE14: lower control 63h selects fast clock, cascaded, flip-flop 0.
// RULE15: upper control bit 3 runs or stops the cascaded pair.
// RULE16: only the upper compare byte takes part in match detection.
// RULE17: software keeps both flip-flop controls at 0 in warm-up mode.
// RULE18: match request stays pending until accepted; one request per match.
// RULE19: clearing run stops at once and clears the counter to zero.
`timescale 1ns/100ps
`default_nettype none
module oscillator_warmup_counter (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic slow_clock,
   input wire logic fast_clock,
   input wire logic irq_accept,
   output logic warmup_match_irq,
   output logic fast_osc_enable,
   output logic slow_osc_enable,
   output logic system_clock_select,
   output logic upper_output_flipflop,
   output logic lower_output_flipflop
);
   logic slow_tick, fast_tick;

   osc_edge_tick u_slow_tick (
      .clk(clk),
      .rst(rst),
      .osc_pin(slow_clock),
      .tick(slow_tick)
   );

   osc_edge_tick u_fast_tick (
      .clk(clk),
      .rst(rst),
      .osc_pin(fast_clock),
      .tick(fast_tick)
   );

   // tick of the count source picked by the lower control clock field
   function automatic logic source_tick(input logic [7:0] ctrl, input logic s_tick,
                                        input logic f_tick);
      logic [2:0] ck;
      ck = ctrl[warmup_pkg::CKSEL_LSB +: 3];
      if (ck == warmup_pkg::CKSEL_SLOW) begin
         source_tick = s_tick;
      end else if (ck == warmup_pkg::CKSEL_FAST) begin
         source_tick = f_tick;
      end else begin
         source_tick = 1'b0;
      end
   endfunction

   // bus
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic bus_req, wr_take;
   logic [7:0] wbyte;

   assign bus_req = wb_cyc_i & wb_stb_i;
   // writes land on the edge that samples ack, as the master expects
   assign wr_take = ack_q & bus_req & wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   logic [7:0] lower_ctrl_q, lower_ctrl_d, upper_ctrl_q, upper_ctrl_d;
   logic [7:0] lower_cmp_q, lower_cmp_d, upper_cmp_q, upper_cmp_d;
   logic [7:0] sysctl_q, sysctl_d;
   logic status_q, status_d, enable_q, enable_d;
   logic [15:0] count_q, count_d;
   warmup_pkg::state_t state_q, state_d;

   logic wr_upper, wr_clear, cascade_ok, run_req, src_tick, match_evt;
   logic [15:0] count_inc;

   assign wr_upper = wr_take && wb_adr_i == warmup_pkg::OFS_UPPER_CTRL;
   assign wr_clear = wr_take && wb_adr_i == warmup_pkg::OFS_IRQ_CLEAR && wbyte[0];
   assign cascade_ok = upper_ctrl_q[2:0] == warmup_pkg::MODE_WARMUP &&
                       lower_ctrl_q[2:0] == warmup_pkg::MODE_CASCADE;
   assign run_req = upper_ctrl_q[warmup_pkg::RUN_BIT] && cascade_ok;
   assign src_tick = source_tick(lower_ctrl_q, slow_tick, fast_tick); // [RULE13] [RULE14]
   assign count_inc = count_q + 16'h0001;
   // lower compare byte is ignored: match lands on upper byte times 256 ticks
   assign match_evt = state_q == warmup_pkg::ST_COUNT && src_tick &&
                      count_inc == {upper_cmp_q, 8'h00}; // [RULE16] [RULE9] [RULE10]

   always_comb begin
      ack_d = bus_req & ~ack_q;
      rdata_d = 32'h0000_0000;
      unique case (wb_adr_i)
         warmup_pkg::OFS_LOWER_CTRL: rdata_d[7:0] = lower_ctrl_q;
         warmup_pkg::OFS_UPPER_CTRL: rdata_d[7:0] = upper_ctrl_q;
         warmup_pkg::OFS_LOWER_CMP: rdata_d[7:0] = lower_cmp_q;
         warmup_pkg::OFS_UPPER_CMP: rdata_d[7:0] = upper_cmp_q;
         warmup_pkg::OFS_SYSCTL: rdata_d[7:0] = sysctl_q;
         warmup_pkg::OFS_COUNT: rdata_d[15:0] = count_q;
         warmup_pkg::OFS_IRQ_STATUS: rdata_d[0] = status_q;
         warmup_pkg::OFS_IRQ_ENABLE: rdata_d[0] = enable_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   // registers
   always_comb begin
      lower_ctrl_d = lower_ctrl_q;
      upper_ctrl_d = upper_ctrl_q;
      lower_cmp_d = lower_cmp_q;
      upper_cmp_d = upper_cmp_q;
      sysctl_d = sysctl_q;
      enable_d = enable_q;
      if (wr_take) begin
         unique case (wb_adr_i)
            warmup_pkg::OFS_LOWER_CTRL: lower_ctrl_d = wbyte; // [RULE13] [RULE14]
            warmup_pkg::OFS_UPPER_CTRL: upper_ctrl_d = wbyte; // [RULE12] [RULE15]
            warmup_pkg::OFS_LOWER_CMP: lower_cmp_d = wbyte;
            warmup_pkg::OFS_UPPER_CMP: upper_cmp_d = wbyte;
            warmup_pkg::OFS_SYSCTL: sysctl_d = {wbyte[7:5], 5'h00}; // [RULE11]
            warmup_pkg::OFS_IRQ_ENABLE: enable_d = wbyte[0];
            default: enable_d = enable_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lower_ctrl_q <= warmup_pkg::RST_CTRL;
         upper_ctrl_q <= warmup_pkg::RST_CTRL;
         lower_cmp_q <= warmup_pkg::RST_CMP;
         upper_cmp_q <= warmup_pkg::RST_CMP;
         sysctl_q <= warmup_pkg::RST_SYSCTL;
         enable_q <= warmup_pkg::RST_IRQ;
      end else begin
         lower_ctrl_q <= lower_ctrl_d;
         upper_ctrl_q <= upper_ctrl_d;
         lower_cmp_q <= lower_cmp_d;
         upper_cmp_q <= upper_cmp_d;
         sysctl_q <= sysctl_d;
         enable_q <= enable_d;
      end
   end

   assign fast_osc_enable = sysctl_q[warmup_pkg::FAST_OSC_BIT]; // [RULE11]
   assign slow_osc_enable = sysctl_q[warmup_pkg::SLOW_OSC_BIT]; // [RULE11]
   assign system_clock_select = sysctl_q[warmup_pkg::SYSCLK_SEL_BIT]; // [RULE11]
   // pins only show what software put there; warm-up never toggles them
   assign upper_output_flipflop = upper_ctrl_q[warmup_pkg::FLIPFLOP_BIT];
   assign lower_output_flipflop = lower_ctrl_q[warmup_pkg::FLIPFLOP_BIT];

   // counter
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      unique case (state_q)
         warmup_pkg::ST_IDLE: begin
            count_d = warmup_pkg::RST_COUNT;
            if (run_req) begin
               state_d = warmup_pkg::ST_COUNT; // [RULE2] [RULE15]
            end
         end
         warmup_pkg::ST_COUNT: begin
            if (!run_req) begin
               state_d = warmup_pkg::ST_IDLE; // [RULE19]
               count_d = warmup_pkg::RST_COUNT;
            end else if (match_evt) begin
               count_d = warmup_pkg::RST_COUNT; // [RULE3]
            end else if (src_tick) begin
               count_d = count_inc;
            end
         end
         default: begin
            state_d = warmup_pkg::ST_IDLE;
            count_d = warmup_pkg::RST_COUNT;
         end
      endcase
      // set wins over a clear in the same cycle
      status_d = status_q;
      if (wr_clear || irq_accept) begin
         status_d = 1'b0;
      end
      if (match_evt) begin
         status_d = 1'b1; // [RULE3] [RULE18]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= warmup_pkg::ST_IDLE;
         count_q <= warmup_pkg::RST_COUNT;
         status_q <= warmup_pkg::RST_IRQ;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         status_q <= status_d;
      end
   end

   assign warmup_match_irq = status_q & enable_q; // [RULE18]

   // checks
   sequence upper_write_s(logic [7:0] v);
      wr_upper && wbyte == v;
   endsequence

   sequence matched_s;
      match_evt ##1 (count_q == 16'h0000 && status_q);
   endsequence

   start_count_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
      (wr_upper && wbyte[warmup_pkg::RUN_BIT] && wbyte[2:0] == warmup_pkg::MODE_WARMUP &&
       lower_ctrl_q[2:0] == warmup_pkg::MODE_CASCADE)
      |=> ##1 state_q == warmup_pkg::ST_COUNT)
      else $error("counter did not start after run write");

   match_clear_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
      match_evt |-> matched_s)
      else $error("match did not clear counter and flag request");

   upper_only_a: assert property (@(posedge clk) disable iff (rst) // [RULE16]
      match_evt |-> count_q[7:0] == 8'hff && count_q[15:8] == upper_cmp_q - 8'h01)
      else $error("match not at upper compare byte boundary");

   stop_clear_a: assert property (@(posedge clk) disable iff (rst) // [RULE19]
      (wr_upper && !wbyte[warmup_pkg::RUN_BIT]) |=> ##1
      (state_q == warmup_pkg::ST_IDLE && count_q == 16'h0000))
      else $error("stop did not clear counter");

   mode_write_a: assert property (@(posedge clk) disable iff (rst) // [RULE12]
      upper_write_s(8'h05) |=> (!upper_output_flipflop && !upper_ctrl_q[warmup_pkg::RUN_BIT])
      ##1 state_q == warmup_pkg::ST_IDLE)
      else $error("05h write did not give idle warm-up mode");

   sysctl_bits_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
      (wr_take && wb_adr_i == warmup_pkg::OFS_SYSCTL) |=>
      {fast_osc_enable, slow_osc_enable, system_clock_select} == $past(wb_dat_i[7:5]))
      else $error("system control bits misplaced");

   count_step_a: assert property (@(posedge clk) disable iff (rst) // [RULE13] [RULE14]
      (state_q == warmup_pkg::ST_COUNT && run_req && !match_evt &&
       source_tick(lower_ctrl_q, slow_tick, fast_tick)) |=> count_q == $past(count_q) + 16'h0001)
      else $error("counter did not step on selected source");

   pending_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE18]
      (status_q && !wr_clear && !irq_accept) |=> status_q)
      else $error("pending request lost");

   single_req_a: assert property (@(posedge clk) disable iff (rst) // [RULE18]
      match_evt |=> !match_evt)
      else $error("two requests for one match");

   // a run bit alone must not start a pair that is not set up as a warm-up cascade
   mode_gate_a: assert property (@(posedge clk) disable iff (rst) // [RULE13] [RULE14]
      !cascade_ok |=> state_q == warmup_pkg::ST_IDLE)
      else $error("counter ran without warm-up cascade modes");

   idle_zero_a: assert property (@(posedge clk) disable iff (rst) // [RULE19]
      state_q == warmup_pkg::ST_IDLE |=> count_q == warmup_pkg::RST_COUNT)
      else $error("stopped counter not held at zero");

   count_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE13] [RULE14]
      (state_q == warmup_pkg::ST_COUNT && run_req && !src_tick)
      |=> count_q == $past(count_q))
      else $error("counter moved without a source tick");

   irq_follow_a: assert property (@(posedge clk) disable iff (rst) // [RULE18]
      (match_evt && enable_q && !(wr_take && wb_adr_i == warmup_pkg::OFS_IRQ_ENABLE))
      |=> warmup_match_irq)
      else $error("enabled match gave no interrupt");

   ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
endmodule // oscillator_warmup_counter
`default_nettype wire

// *** hw/warmup_pkg.sv ***
package warmup_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFS_LOWER_CTRL = 8'h00;
   localparam logic [7:0] OFS_UPPER_CTRL = 8'h04;
   localparam logic [7:0] OFS_LOWER_CMP = 8'h08;
   localparam logic [7:0] OFS_UPPER_CMP = 8'h0c;
   localparam logic [7:0] OFS_SYSCTL = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

   // control field positions
   localparam int FLIPFLOP_BIT = 7;
   localparam int RUN_BIT = 3;
   localparam int CKSEL_LSB = 4;
   localparam int FAST_OSC_BIT = 7;
   localparam int SLOW_OSC_BIT = 6;
   localparam int SYSCLK_SEL_BIT = 5;

   localparam logic [2:0] MODE_WARMUP = 3'h5;
   localparam logic [2:0] MODE_CASCADE = 3'h3;
   localparam logic [2:0] CKSEL_SLOW = 3'h4;
   localparam logic [2:0] CKSEL_FAST = 3'h6;

   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_CMP = 8'hff;
   localparam logic [7:0] RST_SYSCTL = 8'h80;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [0:0] RST_IRQ = 1'h0;

   // compare range; one upper step is 256 source ticks
   localparam logic [15:0] CMP_MIN = 16'h0100;
   localparam logic [15:0] CMP_MAX = 16'hff00;
   localparam int TICKS_PER_STEP = 256;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_COUNT = 2'b01
   } state_t;
endpackage

// *** hw/osc_edge_tick.sv ***
`timescale 1ns/100ps
`default_nettype none
// turns a free-running oscillator pin into one-cycle ticks on clk
module osc_edge_tick (
   input wire logic clk,
   input wire logic rst,
   input wire logic osc_pin,
   output logic tick
);
   logic sync1_q, sync2_q, prev_q, tick_q;
   logic tick_d;

   always_comb begin
      tick_d = sync2_q & ~prev_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         sync1_q <= osc_pin;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule // osc_edge_tick
`default_nettype wire

// *** dv/oscillator_warmup_counter_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
   end \
end
module oscillator_warmup_counter_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, slow_clk = 1'b0, fast_clk = 1'b0, accept = 1'b0;
   logic irq, fast_en, slow_en, clk_sel, up_ff, lo_ff;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   oscillator_warmup_counter dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .slow_clock(slow_clk), .fast_clock(fast_clk), .irq_accept(accept),
      .warmup_match_irq(irq), .fast_osc_enable(fast_en), .slow_osc_enable(slow_en),
      .system_clock_select(clk_sel), .upper_output_flipflop(up_ff),
      .lower_output_flipflop(lo_ff));

   initial begin
      forever #5 clk = ~clk;
   end

   // longest test needs about 2100 cycles; a hang stops here
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one classic cycle; the gap before it keeps cyc low for a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 8'h00, r);
      `CHK(nm, e, r)
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // slow enough for the two-flop pin sampling: 2 cycles high, 2 low
   task automatic ticks(input logic fast, input int n);
      repeat (n) begin
         @(posedge clk);
         if (fast) fast_clk <= 1'b1;
         else slow_clk <= 1'b1;
         idle(2);
         fast_clk <= 1'b0;
         slow_clk <= 1'b0;
         @(posedge clk);
      end
      idle(5);
   endtask

   task automatic t_reset();
      logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
      logic [7:0] exp [9] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) begin
         rd_chk("reset value", ofs[i], {24'h0, exp[i]});
      end
      `CHK("osc pins", 3'b100, {fast_en, slow_en, clk_sel})
      $display("test reset done");
   endtask

   task automatic t_sysctl();
      wr(8'h10, 8'hff);
      rd_chk("sysctl", 8'h10, 32'he0);
      `CHK("osc pins", 3'b111, {fast_en, slow_en, clk_sel})
      wr(8'h24, 8'h00);
      wr(8'h10, 8'h40);
      idle(1);
      `CHK("osc pins", 3'b010, {fast_en, slow_en, clk_sel})
      wr(8'h10, 8'hc0);
      rd_chk("sysctl", 8'h10, 32'hc0);
      $display("test sysctl done");
   endtask

   task automatic t_slow();
      wr(8'h10, 8'hc0);
      wr(8'h00, 8'h43);
      wr(8'h04, 8'h05);
      wr(8'h08, 8'ha5);
      wr(8'h0c, 8'h01);
      wr(8'h20, 8'h01);
      wr(8'h04, 8'h0d);
      ticks(1'b0, 100);
      `CHK("flipflops", 2'b00, {up_ff, lo_ff})
      rd_chk("count", 8'h14, 32'd100);
      wr(8'h04, 8'h05);
      rd_chk("count", 8'h14, 32'h0);
      ticks(1'b0, 3);
      rd_chk("count", 8'h14, 32'h0);
      wr(8'h04, 8'h0d);
      ticks(1'b0, 255);
      `CHK("irq", 1'b0, irq)
      ticks(1'b0, 1);
      `CHK("irq", 1'b1, irq)
      rd_chk("count", 8'h14, 32'h0);
      rd_chk("status", 8'h18, 32'h1);
      @(posedge clk);
      accept <= 1'b1;
      @(posedge clk);
      accept <= 1'b0;
      idle(2);
      `CHK("irq", 1'b0, irq)
      wr(8'h04, 8'h05);
      wr(8'h10, 8'he0);
      wr(8'h10, 8'h60);
      idle(1);
      `CHK("osc pins", 3'b011, {fast_en, slow_en, clk_sel})
      $display("test slow done");
   endtask

   task automatic t_fast();
      wr(8'h10, 8'he0);
      wr(8'h00, 8'h63);
      wr(8'h04, 8'h05);
      wr(8'h0c, 8'h02);
      wr(8'h20, 8'h00);
      wr(8'h04, 8'h0d);
      ticks(1'b1, 511);
      rd_chk("status", 8'h18, 32'h0);
      ticks(1'b1, 1);
      rd_chk("status", 8'h18, 32'h1);
      `CHK("masked irq", 1'b0, irq)
      wr(8'h20, 8'h01);
      idle(1);
      `CHK("irq", 1'b1, irq)
      wr(8'h1c, 8'h01);
      idle(1);
      `CHK("irq", 1'b0, irq)
      wr(8'h04, 8'h05);
      wr(8'h10, 8'hc0);
      wr(8'h10, 8'h80);
      idle(1);
      `CHK("osc pins", 3'b100, {fast_en, slow_en, clk_sel})
      $display("test fast done");
   endtask

   initial begin
      idle(4);
      rst <= 1'b0;
      t_reset();
      t_sysctl();
      t_slow();
      t_fast();
      tally_and_finish();
   end
endmodule // oscillator_warmup_counter_tb
`default_nettype wire
